/* rtl/adc_ctrl_pkg.sv */
// Package for the converter control block: register map, field layout,
// reset values, timing counts and the bus carriers.
// Assumes a 25 MHz register clock and a 32-bit APB master.
package adc_ctrl_pkg;

   // Clock and timing
   localparam int unsigned REF_CLK_HZ = 25_000_000;
   localparam int unsigned WAKE_GLOBAL_US = 100;
   localparam int unsigned WAKE_STANDBY_US = 50;
   localparam int unsigned CLK_STOP_NS = 1000;
   localparam int unsigned WAKE_GLOBAL_CYC = WAKE_GLOBAL_US * (REF_CLK_HZ / 1_000_000);
   localparam int unsigned WAKE_STANDBY_CYC = WAKE_STANDBY_US * (REF_CLK_HZ / 1_000_000);
   localparam int unsigned CLK_STOP_CYC = CLK_STOP_NS * (REF_CLK_HZ / 1_000_000) / 1000;
   localparam int unsigned RAW_LATENCY = 16;

   // Sample and offset loop arithmetic
   localparam int unsigned SAMPLE_W = 14;
   localparam int unsigned EST_FRAC = 31;
   localparam int unsigned ACC_W = SAMPLE_W + EST_FRAC + 2;
   localparam int unsigned TC_BASE_LOG2 = 20;
   localparam logic [3:0] TC_MAX_CODE = 4'hb;
   localparam logic [3:0] TC_RESET_CODE = 4'h0;
   localparam logic [3:0] TC_SHIFT_TOP = 4'(EST_FRAC - TC_BASE_LOG2);
   localparam int unsigned OFFSET_LIMIT_MV = 10;
   localparam int unsigned FULL_SCALE_MV = 2000;
   localparam int unsigned OFFSET_LIMIT_CODES = OFFSET_LIMIT_MV * (1 << SAMPLE_W) / FULL_SCALE_MV;
   localparam logic signed [ACC_W-1:0] EST_LIMIT_ACC = ACC_W'(OFFSET_LIMIT_CODES) << EST_FRAC;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_EST_A = 8'h08;
   localparam logic [7:0] OFF_EST_B = 8'h0c;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_0fff;

   // Control pin codes, ordered {three, two, one}
   localparam logic [2:0] PINS_GLOBAL_SLEEP = 3'h1;
   localparam logic [2:0] PINS_STANDBY_A = 3'h5;
   localparam logic [2:0] PINS_MUX = 3'h7;

   // Control register layout, bit 0 at the bottom
   typedef struct packed {
      logic [19:0] rsvd;
      logic lvds_sel;
      logic mux_bit;
      logic standby_b;
      logic standby_a;
      logic full_sleep_bit;
      logic [3:0] dc_loop_tc_select;
      logic dc_estimate_hold;
      logic dc_cancel_enable;
      logic digital_enable;
   } ctrl_reg_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   typedef enum logic [1:0] {PWR_ON, PWR_SLEEP, PWR_WAKE} pwr_state_t;

endpackage

/* rtl/adc_offset_power_control.sv */
// Digital control of a dual-channel 14-bit converter: offset loop, power
// modes, multiplexed output, clock-stop detection and interface select.
// Assumes conv_clk_i and all pins are asynchronous to ref_clk_i, with
// conv_clk_i well below half the rate of ref_clk_i.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module adc_offset_power_control
   import adc_ctrl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire apb_req_t apb_req_i,
   output apb_rsp_t apb_rsp_o,
   input wire logic conv_clk_i,
   input wire logic [SAMPLE_W-1:0] sample_a_i,
   input wire logic [SAMPLE_W-1:0] sample_b_i,
   input wire logic mode_pin_one_i,
   input wire logic mode_pin_two_i,
   input wire logic mode_pin_three_i,
   input wire logic serial_select_pin_i,
   input wire logic parallel_cfg_i,
   output logic [SAMPLE_W-1:0] channel_a_bus_o,
   output logic channel_a_oe_b_o,
   output logic [SAMPLE_W-1:0] channel_b_bus_o,
   output logic channel_b_oe_b_o,
   output logic out_clk_o,
   output logic out_clk_oe_b_o,
   output logic valid_a_o,
   output logic valid_b_o,
   output logic lvds_select_o,
   output logic low_power_o
);

   typedef logic signed [ACC_W-1:0] acc_t;
   typedef logic signed [SAMPLE_W-1:0] smp_t;

   typedef struct packed {
      ctrl_reg_t ctrl;
      logic [1:0] ck_sync;
      logic ck_prev;
      logic [1:0][2:0] pin_sync;
      logic [1:0] sel_sync;
      logic [1:0] cfg_sync;
      logic [1:0][SAMPLE_W-1:0] a_sync;
      logic [1:0][SAMPLE_W-1:0] b_sync;
      logic [RAW_LATENCY-1:0][2*SAMPLE_W-1:0] pipe;
      acc_t acc_a;
      acc_t acc_b;
      pwr_state_t pwr;
      logic [11:0] wake_cnt;
      logic [10:0] stby_cnt_a;
      logic [10:0] stby_cnt_b;
      logic [4:0] stop_cnt;
      logic [SAMPLE_W-1:0] mux_hold;
      apb_rsp_t rsp;
      logic [SAMPLE_W-1:0] bus_a;
      logic [SAMPLE_W-1:0] bus_b;
      logic oe_a_b;
      logic oe_b_b;
      logic out_clk;
      logic valid_a;
      logic valid_b;
      logic lvds;
      logic low_power;
   } state_t;

   state_t st_q;
   state_t st_d;

   // Reserved codes behave as the reset code
   function automatic logic [3:0] tc_code(input logic [3:0] tc);
      tc_code = (tc > TC_MAX_CODE) ? TC_RESET_CODE : tc;
   endfunction

   function automatic smp_t est_of(input acc_t acc);
      est_of = SAMPLE_W'(acc >>> EST_FRAC);
   endfunction

   // One loop step: estimate moves by error / 2^(20+code), clamped to the limit
   function automatic acc_t loop_step(input acc_t acc, input smp_t x, input logic [3:0] tc);
      acc_t err;
      acc_t nxt;
      logic [3:0] sh;
      sh = TC_SHIFT_TOP - tc_code(tc);
      err = ACC_W'(x) - (acc >>> EST_FRAC);
      nxt = acc + (err <<< sh);
      if (nxt > EST_LIMIT_ACC) begin
         nxt = EST_LIMIT_ACC;
      end else if (nxt < -EST_LIMIT_ACC) begin
         nxt = -EST_LIMIT_ACC;
      end
      loop_step = nxt;
   endfunction

   // Subtract with saturation so a correction never wraps a full-scale word
   function automatic logic [SAMPLE_W-1:0] sat_sub(input smp_t x, input smp_t e);
      logic signed [SAMPLE_W:0] diff;
      diff = (SAMPLE_W+1)'(x) - (SAMPLE_W+1)'(e);
      if (diff[SAMPLE_W] != diff[SAMPLE_W-1]) begin
         sat_sub = diff[SAMPLE_W] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else begin
         sat_sub = diff[SAMPLE_W-1:0];
      end
   endfunction

   // Decoded modes and loop enables
   logic rise;
   logic fall;
   logic [2:0] pins;
   logic gsleep;
   logic stby_a;
   logic stby_b;
   logic mux_eff;
   logic corr_on;
   logic tracking;
   logic clk_stopped;
   logic running;
   logic access;
   smp_t raw_a;
   smp_t raw_b;
   logic [SAMPLE_W-1:0] out_a;
   logic [SAMPLE_W-1:0] out_b;

   always_comb begin
      rise = st_q.ck_sync[1] & ~st_q.ck_prev;
      fall = ~st_q.ck_sync[1] & st_q.ck_prev;
      pins = st_q.pin_sync[1];
      gsleep = st_q.ctrl.full_sleep_bit | (pins == PINS_GLOBAL_SLEEP);
      stby_a = st_q.ctrl.standby_a | (pins == PINS_STANDBY_A);
      stby_b = st_q.ctrl.standby_b;
      mux_eff = st_q.ctrl.mux_bit | (pins == PINS_MUX);
      corr_on = st_q.ctrl.digital_enable & st_q.ctrl.dc_cancel_enable;
      tracking = corr_on & st_q.ctrl.dc_estimate_hold;
      clk_stopped = (st_q.stop_cnt == 5'(CLK_STOP_CYC));
      running = (st_q.pwr == PWR_ON) & ~clk_stopped;
      access = st_q.rsp.pready & apb_req_i.psel & apb_req_i.penable;
      raw_a = st_q.pipe[RAW_LATENCY-1][2*SAMPLE_W-1:SAMPLE_W];
      raw_b = st_q.pipe[RAW_LATENCY-1][SAMPLE_W-1:0];
      out_a = corr_on ? sat_sub(raw_a, est_of(st_q.acc_a)) : raw_a;
      out_b = corr_on ? sat_sub(raw_b, est_of(st_q.acc_b)) : raw_b;
   end

   // Whole next state; registered below in one flop bank
   always_comb begin
      st_d = st_q;
      // Two-flop synchronisers for every pin and the sample clock
      st_d.ck_sync = {st_q.ck_sync[0], conv_clk_i};
      st_d.ck_prev = st_q.ck_sync[1];
      st_d.pin_sync = {st_q.pin_sync[0], {mode_pin_three_i, mode_pin_two_i, mode_pin_one_i}};
      st_d.sel_sync = {st_q.sel_sync[0], serial_select_pin_i};
      st_d.cfg_sync = {st_q.cfg_sync[0], parallel_cfg_i};
      st_d.a_sync = {st_q.a_sync[0], sample_a_i};
      st_d.b_sync = {st_q.b_sync[0], sample_b_i};

      // Clock-stop watchdog, restarted by every rising sample clock edge
      if (rise) begin
         st_d.stop_cnt = '0;
      end else if (!clk_stopped) begin
         st_d.stop_cnt = st_q.stop_cnt + 5'h01;
      end

      // Global power state with wake-up delay
      unique case (st_q.pwr)
         PWR_ON: begin
            if (gsleep) begin
               st_d.pwr = PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            if (!gsleep) begin
               st_d.pwr = PWR_WAKE;
               st_d.wake_cnt = 12'(WAKE_GLOBAL_CYC - 1);
            end
         end
         PWR_WAKE: begin
            if (gsleep) begin
               st_d.pwr = PWR_SLEEP;
            end else if (st_q.wake_cnt == '0) begin
               st_d.pwr = PWR_ON;
            end else begin
               st_d.wake_cnt = st_q.wake_cnt - 12'h001;
            end
         end
      endcase

      // Per-channel standby timers, reloaded while standing by
      if (stby_a) begin
         st_d.stby_cnt_a = 11'(WAKE_STANDBY_CYC);
      end else if (st_q.stby_cnt_a != '0) begin
         st_d.stby_cnt_a = st_q.stby_cnt_a - 11'h001;
      end
      if (stby_b) begin
         st_d.stby_cnt_b = 11'(WAKE_STANDBY_CYC);
      end else if (st_q.stby_cnt_b != '0) begin
         st_d.stby_cnt_b = st_q.stby_cnt_b - 11'h001;
      end

      // Sample path: fixed-latency pipe plus offset loop, one step per sample
      if (rise) begin
         st_d.pipe = {st_q.pipe[RAW_LATENCY-2:0], {st_q.a_sync[1], st_q.b_sync[1]}};
         if (tracking && st_q.pwr == PWR_ON) begin
            if (!stby_a) begin
               st_d.acc_a = loop_step(st_q.acc_a, raw_a, st_q.ctrl.dc_loop_tc_select);
            end
            if (!stby_b) begin
               st_d.acc_b = loop_step(st_q.acc_b, raw_b, st_q.ctrl.dc_loop_tc_select);
            end
         end
      end

      // Output drivers; enables are active low
      if (st_q.pwr == PWR_SLEEP) begin
         st_d.oe_a_b = 1'b1;
         st_d.oe_b_b = 1'b1;
         st_d.bus_a = '0;
         st_d.bus_b = '0;
         st_d.out_clk = 1'b0;
      end else begin
         st_d.oe_a_b = mux_eff;
         st_d.oe_b_b = 1'b0;
         if (running) begin
            st_d.out_clk = st_q.ck_sync[1];
            if (rise) begin
               st_d.bus_a = stby_a ? '0 : out_a;
               st_d.bus_b = mux_eff ? out_a : (stby_b ? '0 : out_b);
               st_d.mux_hold = out_b;
            end else if (fall && mux_eff) begin
               st_d.bus_b = st_q.mux_hold;
            end
         end
      end
      st_d.valid_a = running & ~mux_eff & ~stby_a & (st_q.stby_cnt_a == '0);
      st_d.valid_b = running & ~stby_b & (st_q.stby_cnt_b == '0);
      st_d.low_power = clk_stopped;
      st_d.lvds = st_q.cfg_sync[1] ? st_q.sel_sync[1] : st_q.ctrl.lvds_sel;

      // APB slave: one wait state, write and read data at the pready edge
      st_d.rsp.pready = apb_req_i.psel & apb_req_i.penable & ~st_q.rsp.pready;
      if (apb_req_i.psel && apb_req_i.penable && !st_q.rsp.pready) begin
         st_d.rsp.pslverr = 1'b0;
         unique case (apb_req_i.paddr)
            OFF_CTRL: st_d.rsp.prdata = st_q.ctrl;
            OFF_STATUS: begin
               st_d.rsp.prdata = {25'h0000000, clk_stopped, mux_eff, st_q.lvds, st_q.valid_b,
                                  st_q.valid_a, st_q.pwr == PWR_WAKE, st_q.pwr == PWR_SLEEP};
            end
            OFF_EST_A: st_d.rsp.prdata = 32'(est_of(st_q.acc_a));
            OFF_EST_B: st_d.rsp.prdata = 32'(est_of(st_q.acc_b));
            default: begin
               st_d.rsp.prdata = '0;
               st_d.rsp.pslverr = 1'b1;
            end
         endcase
      end
      if (access && apb_req_i.pwrite && apb_req_i.paddr == OFF_CTRL) begin
         st_d.ctrl = apb_req_i.pwdata & CTRL_WMASK;
      end
   end

   // Single flop bank with synchronous reset
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_q <= '0;
         st_q.ctrl <= CTRL_RESET;
         st_q.pwr <= PWR_ON;
         st_q.oe_a_b <= 1'b0;
         st_q.oe_b_b <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign apb_rsp_o = st_q.rsp;
   assign channel_a_bus_o = st_q.bus_a;
   assign channel_a_oe_b_o = st_q.oe_a_b;
   assign channel_b_bus_o = st_q.bus_b;
   assign channel_b_oe_b_o = st_q.oe_b_b;
   assign out_clk_o = st_q.out_clk;
   assign out_clk_oe_b_o = st_q.oe_b_b;
   assign valid_a_o = st_q.valid_a;
   assign valid_b_o = st_q.valid_b;
   assign lvds_select_o = st_q.lvds;
   assign low_power_o = st_q.low_power;

   // Checks on the block's own behaviour
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_reset_corr_off: assert property ($rose(rst_b_i) |-> !corr_on && st_q.acc_a == '0)
      else $error("correction active right after reset");
   a_sleep_floats: assert property (gsleep && st_q.pwr == PWR_ON |=> ##1 channel_a_oe_b_o && channel_b_oe_b_o)
      else $error("outputs driven in global sleep");
   a_wake_invalid: assert property ($fell(st_q.pwr == PWR_SLEEP) && !gsleep |=> !valid_a_o && !valid_b_o [*8])
      else $error("data valid during wake-up");
   a_wake_bound: assert property (st_q.pwr == PWR_WAKE |-> st_q.wake_cnt < 12'(WAKE_GLOBAL_CYC))
      else $error("wake counter beyond its delay");
   a_mux_a_float: assert property (mux_eff && st_q.pwr != PWR_SLEEP |=> channel_a_oe_b_o)
      else $error("channel A bus driven in multiplexed mode");
   a_frozen_hold: assert property (corr_on && !st_q.ctrl.dc_estimate_hold |=> $stable(st_q.acc_a))
      else $error("frozen estimate changed");
   a_est_limit: assert property (est_of(st_q.acc_a) <= smp_t'(OFFSET_LIMIT_CODES)
                                 && est_of(st_q.acc_a) >= -smp_t'(OFFSET_LIMIT_CODES))
      else $error("offset estimate beyond its limit");
   a_tc_reserved: assert property (st_q.ctrl.dc_loop_tc_select > TC_MAX_CODE
                                   |-> tc_code(st_q.ctrl.dc_loop_tc_select) == TC_RESET_CODE)
      else $error("reserved time constant not defaulted");
   a_clk_stop_lp: assert property (clk_stopped |=> low_power_o && !valid_a_o && !valid_b_o)
      else $error("stopped clock not in low power");
   // The pipe shifts on the same edge, so compare with the word that was at its end
   a_raw_path: assert property (!corr_on && running && rise && !mux_eff && !stby_b |=> channel_b_bus_o == $past(raw_b))
      else $error("raw data not passed through");
   a_stby_b_valid: assert property (stby_b |=> !valid_b_o)
      else $error("channel B valid while standing by");

endmodule

/* bench/adc_rx_model.sv */
// Receiver model: while valid_b_i is high, latches both output buses at each rising output clock edge, and bus B alone at each falling one.
// Assumes out_clk_i is already synchronous to ref_clk_i.
`timescale 1ns/1ps
module adc_rx_model
   import adc_ctrl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [SAMPLE_W-1:0] bus_a_i,
   input wire logic [SAMPLE_W-1:0] bus_b_i,
   input wire logic out_clk_i,
   input wire logic valid_b_i,
   output logic [SAMPLE_W-1:0] word_a_o,
   output logic [SAMPLE_W-1:0] word_b_o,
   output logic [SAMPLE_W-1:0] late_b_o,
   output logic [15:0] words_o
);
   logic clk_q;

   // Bus changes with the clock edge, so the edge cycle already holds the word
   always_ff @(posedge ref_clk_i) begin
      clk_q <= out_clk_i;
      if (!rst_b_i) begin
         word_a_o <= '0;
         word_b_o <= '0;
         late_b_o <= '0;
         words_o <= 16'h0000;
      end else if (valid_b_i) begin
         if (out_clk_i && !clk_q) begin
            word_a_o <= bus_a_i;
            word_b_o <= bus_b_i;
            words_o <= words_o + 16'h0001;
         end
         if (!out_clk_i && clk_q) begin
            late_b_o <= bus_b_i; // Second half of a mux period
         end
      end
   end
endmodule

/* bench/adc_offset_power_control_tb_top.sv */
// Testbench for the converter control block: APB access, mode pins,
// sample latency, multiplexing, sleep, standby and clock stop.
// Assumes the receiver model and a 320 ns sampling clock made here.
`timescale 1ns/1ps
module adc_offset_power_control_tb_top
   import adc_ctrl_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic conv_clk_i = 1'b0;
   logic conv_run = 1'b1;
   apb_req_t apb_req = '0;
   apb_rsp_t apb_rsp;
   logic [SAMPLE_W-1:0] sample_a = '0, sample_b = '0;
   logic [SAMPLE_W-1:0] next_a = 14'h0123, next_b = 14'h3abc;
   logic [2:0] pins = 3'h0;
   logic sel_pin = 1'b0, par_cfg = 1'b0;
   logic [SAMPLE_W-1:0] bus_a, bus_b, rx_a, rx_b, rx_late;
   logic oe_a_b, oe_b_b, oclk, oclk_oe_b, valid_a, valid_b, lvds, low_pwr;
   logic [15:0] rx_words, n_words;
   logic [1:0] div = 2'h0;
   int err_count = 0, checks_done = 0, cycles = 0, rises = 0;

   adc_offset_power_control uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .apb_req_i(apb_req),
      .apb_rsp_o(apb_rsp), .conv_clk_i(conv_clk_i), .sample_a_i(sample_a), .sample_b_i(sample_b),
      .mode_pin_one_i(pins[0]), .mode_pin_two_i(pins[1]), .mode_pin_three_i(pins[2]),
      .serial_select_pin_i(sel_pin), .parallel_cfg_i(par_cfg), .channel_a_bus_o(bus_a),
      .channel_a_oe_b_o(oe_a_b), .channel_b_bus_o(bus_b), .channel_b_oe_b_o(oe_b_b),
      .out_clk_o(oclk), .out_clk_oe_b_o(oclk_oe_b), .valid_a_o(valid_a), .valid_b_o(valid_b),
      .lvds_select_o(lvds), .low_power_o(low_pwr));

   adc_rx_model rx (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_a_i(bus_a), .bus_b_i(bus_b),
      .out_clk_i(oclk), .valid_b_i(valid_b), .word_a_o(rx_a), .word_b_o(rx_b), .late_b_o(rx_late),
      .words_o(rx_words));

   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // Sampling clock at 8 ref cycles; samples change on its falling edge
   always @(posedge ref_clk_i) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
         conv_clk_i <= conv_run & ~conv_clk_i;
         if (conv_clk_i) begin
            sample_a <= next_a;
            sample_b <= next_b;
         end else if (conv_run) begin
            rises <= rises + 1;
         end
      end
   end

   // Hang guard, well above the few thousand cycles the tests need
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                           output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge ref_clk_i);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         check("pready", 32'h0, 32'h1);
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      logic e;
      apb_xfer(1'b1, a, wd, d, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      logic [31:0] d;
      logic e;
      apb_xfer(1'b0, a, 32'h0, d, e);
      check(name, d, exp);
   endtask

   task automatic set_pins(input logic [2:0] c);
      @(posedge ref_clk_i);
      pins <= c;
      repeat (10) @(posedge ref_clk_i);
   endtask

   task automatic wait_rises(input int n);
      int t;
      t = rises + n;
      while (rises < t) @(posedge ref_clk_i);
      repeat (4) @(posedge ref_clk_i);
   endtask

   initial begin
      logic [31:0] d;
      logic e;
      repeat (20) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      // Register defaults, masking and refused accesses
      rd_chk(OFF_CTRL, CTRL_RESET, "ctrl reset");
      apb_xfer(1'b0, 8'h10, 32'h0, d, e);
      check("unmapped data", d, 32'h0);
      check("unmapped error", 32'(e), 32'h1);
      wr(OFF_CTRL, 32'hffff_f804);
      rd_chk(OFF_CTRL, 32'h0000_0804, "ctrl mask");
      check("lvds reg", 32'(lvds), 32'h1);
      wr(OFF_CTRL, 32'h0000_0006);
      wait_rises(4);
      rd_chk(OFF_EST_A, 32'h0, "estimate without digital enable");
      wr(OFF_CTRL, CTRL_RESET);
      par_cfg <= 1'b1;
      sel_pin <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      check("lvds pin high", 32'(lvds), 32'h1);
      sel_pin <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      check("lvds pin low", 32'(lvds), 32'h0);
      par_cfg <= 1'b0;
      $display("test registers done");
      // Raw path latency of 16 samples
      wait_rises(20);
      check("bus a", 32'(bus_a), 32'h0123);
      check("bus b", 32'(bus_b), 32'h3abc);
      next_a = 14'h1555;
      wait_rises(14);
      check("bus a early", 32'(bus_a), 32'h0123);
      wait_rises(5);
      check("bus a late", 32'(bus_a), 32'h1555);
      check("receiver a", 32'(rx_a), 32'h1555);
      $display("test latency done");
      // Digital enable first, then correction with the estimate frozen
      wr(OFF_CTRL, 32'h0000_0001);
      wr(OFF_CTRL, 32'h0000_0003);
      wait_rises(4);
      rd_chk(OFF_EST_A, 32'h0, "frozen estimate a");
      rd_chk(OFF_EST_B, 32'h0, "frozen estimate b");
      check("frozen bus a", 32'(bus_a), 32'h1555);
      wr(OFF_CTRL, CTRL_RESET);
      $display("test frozen loop done");
      // Every pin code except sleep; unavailable ones act as normal
      for (int c = 0; c < 8; c++) begin
         if (c != 1) begin
            set_pins(3'(c));
            check("oe a", 32'(oe_a_b), 32'(c == 7));
            check("oe b", 32'(oe_b_b), 32'h0);
         end
      end
      wait_rises(4);
      check("mux first", 32'(rx_b), 32'h1555);
      check("mux second", 32'(rx_late), 32'h3abc);
      set_pins(3'h5);
      wait_rises(2);
      check("standby valid a", 32'(valid_a), 32'h0);
      check("standby bus a", 32'(bus_a), 32'h0);
      check("standby valid b", 32'(valid_b), 32'h1);
      set_pins(3'h0);
      repeat (1000) @(posedge ref_clk_i);
      check("standby wake early", 32'(valid_a), 32'h0);
      repeat (400) @(posedge ref_clk_i);
      check("standby wake late", 32'(valid_a), 32'h1);
      $display("test pins done");
      // Sleep by pin, then by register, then the wake-up window
      set_pins(3'h1);
      check("sleep oe", {oe_a_b, oe_b_b, oclk_oe_b}, 32'h7);
      set_pins(3'h0);
      wr(OFF_CTRL, CTRL_RESET | 32'h0000_0080);
      repeat (4) @(posedge ref_clk_i);
      check("reg sleep oe", {oe_a_b, oe_b_b, oclk_oe_b}, 32'h7);
      wr(OFF_CTRL, CTRL_RESET);
      n_words = rx_words;
      repeat (2000) @(posedge ref_clk_i);
      check("wake valid early", 32'(valid_b), 32'h0);
      check("wake words", 32'(rx_words), 32'(n_words));
      repeat (700) @(posedge ref_clk_i);
      check("wake valid late", 32'(valid_b), 32'h1);
      $display("test sleep done");
      // Stopped sampling clock forces the low-power state
      conv_run <= 1'b0;
      repeat (60) @(posedge ref_clk_i);
      check("low power", 32'(low_pwr), 32'h1);
      check("stopped valid", 32'(valid_b), 32'h0);
      rd_chk(OFF_STATUS, 32'h0000_0040, "status stopped");
      conv_run <= 1'b1;
      wait_rises(3);
      check("low power exit", 32'(low_pwr), 32'h0);
      $display("test clock stop done");
      // Channel B standby requested by its register bit
      wr(OFF_CTRL, CTRL_RESET | 32'h0000_0200);
      wait_rises(2);
      check("reg standby valid b", 32'(valid_b), 32'h0);
      check("reg standby bus b", 32'(bus_b), 32'h0);
      wr(OFF_CTRL, CTRL_RESET);
      $display("test standby b done");
      report_and_stop();
   end
endmodule
